// >>> pkg/ocp_consts.svh
// Constants of the output compare channel: offsets, field positions, resets, timing.
// Assumes a 16-bit register word and a 20 MHz system clock.
`ifndef OCP_CONSTS_SVH
`define OCP_CONSTS_SVH

// Register indices on the plain register port
`define OCP_ADDR_W 3
`define OCP_OFS_CTRL_ONE 3'h0
`define OCP_OFS_CTRL_TWO 3'h1
`define OCP_OFS_PRIMARY 3'h2
`define OCP_OFS_SECONDARY 3'h3
`define OCP_OFS_TIMER 3'h4

// Control one fields
`define OCP_C1_MODE_LSB 0
`define OCP_C1_AUTOCLR 3
`define OCP_C1_FLAG_LSB 4
`define OCP_C1_FEN_LSB 7

// Control two fields
`define OCP_C2_SRC_LSB 0
`define OCP_C2_TRIS 5
`define OCP_C2_TRIGGER_STATUS 6
`define OCP_C2_TRIG 7
`define OCP_C2_CASCADE 8
`define OCP_C2_DCB_LSB 9
`define OCP_C2_UNUSED 11
`define OCP_C2_INVERT 12
`define OCP_C2_FDIR 13
`define OCP_C2_FLEVEL 14
`define OCP_C2_FHOLD 15

// Reset values
`define OCP_RST_CTRL_ONE 16'h0000
`define OCP_RST_CTRL_TWO 16'h000c
`define OCP_RST_COMPARE 16'h0000

// Mode codes
`define OCP_MODE_OFF 3'h0
`define OCP_MODE_SS_HIGH 3'h1
`define OCP_MODE_SS_LOW 3'h2
`define OCP_MODE_TOGGLE 3'h3
`define OCP_MODE_DBL_ONE 3'h4
`define OCP_MODE_DBL_CONT 3'h5
`define OCP_MODE_PWM_EDGE 3'h6
`define OCP_MODE_PWM_CENTER 3'h7

// Source codes
`define OCP_SRC_NONE 5'h00
`define OCP_SRC_SELF 5'h1f

// Timing: instruction cycle in ns and in system clocks
`define OCP_CLK_MHZ 20
`define OCP_TCY_NS 200
`define OCP_TCY_CLKS ((`OCP_TCY_NS * `OCP_CLK_MHZ) / 1000)

`endif

// >>> pkg/ocp_pkg.sv
// Types of the output compare channel.
// Assumes ocp_consts.svh supplies the numeric layout.
package ocp_pkg;

    typedef enum logic [1:0] {
        SHOT_ARMED,
        SHOT_SECOND,
        SHOT_DONE
    } ocp_shot_e;

    typedef struct packed {
        logic [2:0] mode;
        logic autoclr;
        logic [2:0] fen;
        logic [2:0] fflag;
        logic [15:0] con2;
        logic [15:0] pri;
        logic [15:0] sec;
        logic [15:0] pri_act;
        logic [15:0] sec_act;
        logic [1:0] dcb_act;
        logic [15:0] tmr;
        logic [7:0] phase;
        logic core;
        ocp_shot_e shot;
        logic [7:0] dly;
        logic lvl;
        logic [15:0] rdata;
        logic [2:0] fs1;
        logic [2:0] fs2;
        logic [2:0] fs3;
        logic [2:0] fq;
    } ocp_state_s;

endpackage

// >>> hdl/ocp_channel.sv
// Output compare channel: mode logic, second control register, faults, PWM.
// Assumes same-clock source events and cascade peer signals; fault pins are asynchronous.
// Behaviour
// - Mode 111 center PWM, 110 edge PWM
// - Mode 101 toggles alternately, starting low
// - Mode 100 gives one pulse, starting low
// - Mode 011 toggles on every compare
// - Mode 010 starts high, goes low once
// - Mode 001 starts low, goes high once
// - Mode 000 disables compare activity
// - Fault hold: software clear versus period end
// - Fault drives output to chosen level
// - Fault may force pin to output
// - Invert select inverts channel output
// - Sub-cycle field delays falling edge
// - Delay moves rising edge when inverted
// - Cascade joins two channels into 32 bits
// - Select trigger or sync from source
// - Trigger status shows timer running
// - Tristate select releases the pin
// - Five-bit field selects the source
// - Auto-clear trigger status on secondary match
// - Fault flags set by hardware, center PWM
// - PWM compare values update at period end
// - Each fault input needs its enable
//
// The plain strobed port and the placing of the registers were left to the implementer.
`include "ocp_consts.svh"

module ocp_channel #(
    parameter int TCY_CLKS = `OCP_TCY_CLKS,
    parameter int FAULT_INPUTS = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [`OCP_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Trigger and sync sources, one-cycle pulses indexed by source code
    input wire logic [31:0] source_events,
    // Fault inputs, asynchronous
    input wire logic [FAULT_INPUTS-1:0] fault_in,
    // Cascade peer
    input wire logic cascade_carry_in,
    input wire logic cascade_match_in,
    output logic cascade_carry_out,
    output logic cascade_match_out,
    // Output pin
    output logic compare_output_pin_out,
    output logic compare_output_pin_oe
);

    ocp_pkg::ocp_state_s s_r;
    ocp_pkg::ocp_state_s s_nxt;

    localparam int QUARTER = TCY_CLKS / 4;

    // Quarter steps must be whole clocks and fit the 8-bit counters
    if (TCY_CLKS < 4 || (TCY_CLKS % 4) != 0 || TCY_CLKS > 252 || FAULT_INPUTS != 3) begin
        $error("ocp_channel: unsupported parameter values");
    end

    logic [2:0] mode;
    logic [4:0] src;
    logic trig_mode;
    logic cascade;
    logic pwm;
    logic tick;
    logic pri_hit;
    logic sec_hit;
    logic sel_evt;
    logic hold_clear;
    logic period_start;
    logic [15:0] tmr_inc;
    logic [2:0] fault_live;
    logic fault_active;
    logic wr_c1;
    logic wr_c2;

    assign mode = s_r.mode;
    assign src = s_r.con2[`OCP_C2_SRC_LSB +: 5];
    assign trig_mode = s_r.con2[`OCP_C2_TRIG];
    assign cascade = s_r.con2[`OCP_C2_CASCADE];
    assign pwm = (mode == `OCP_MODE_PWM_EDGE) || (mode == `OCP_MODE_PWM_CENTER);
    assign wr_c1 = reg_wr && (reg_addr == `OCP_OFS_CTRL_ONE);
    assign wr_c2 = reg_wr && (reg_addr == `OCP_OFS_CTRL_TWO);
    // Cascaded: the upper half counts on the lower half's carry
    assign tick = cascade ? cascade_carry_in
        : (s_r.phase == 8'(TCY_CLKS - 1));
    assign tmr_inc = s_r.tmr + 16'h0001;
    // Cascaded matches need the peer half to match too
    assign pri_hit = tick && (s_r.tmr == s_r.pri_act)
        && (!cascade || cascade_match_in);
    assign sec_hit = tick && (s_r.tmr == s_r.sec_act)
        && (!cascade || cascade_match_in);
    // Own secondary match stands in for the self code
    assign sel_evt = (src == `OCP_SRC_SELF) ? sec_hit
        : (src != `OCP_SRC_NONE) && source_events[src];
    assign hold_clear = trig_mode && !s_r.con2[`OCP_C2_TRIGGER_STATUS];
    assign period_start = tick && !hold_clear && (sel_evt || (s_r.tmr == 16'hffff));
    assign fault_live = s_r.fq & s_r.fen;
    assign fault_active = (mode == `OCP_MODE_PWM_CENTER) && (|s_r.fflag);
    assign cascade_carry_out = (s_r.phase == 8'(TCY_CLKS - 1)) && (s_r.tmr == 16'hffff)
        && !hold_clear;
    assign cascade_match_out = (s_r.tmr == s_r.pri_act);
    assign reg_rdata = s_r.rdata;

    always_comb begin
        s_nxt = s_r;

        // Fault pins: a change counts once second and third stages agree
        s_nxt.fs1 = fault_in;
        s_nxt.fs2 = s_r.fs1;
        s_nxt.fs3 = s_r.fs2;
        for (int i = 0; i < 3; i++) begin
            if (s_r.fs2[i] == s_r.fs3[i]) begin
                s_nxt.fq[i] = s_r.fs3[i];
            end
        end

        // Count clock divider
        if (s_r.phase == 8'(TCY_CLKS - 1)) begin
            s_nxt.phase = 8'h00;
        end else begin
            s_nxt.phase = s_r.phase + 8'h01;
        end

        // Register writes
        if (wr_c1) begin
            s_nxt.mode = reg_wdata[`OCP_C1_MODE_LSB +: 3];
            s_nxt.autoclr = reg_wdata[`OCP_C1_AUTOCLR];
            s_nxt.fen = reg_wdata[`OCP_C1_FEN_LSB +: 3];
            // Flags clear by software only under fault hold, once the source is gone
            for (int i = 0; i < 3; i++) begin
                if (s_r.con2[`OCP_C2_FHOLD] && !reg_wdata[`OCP_C1_FLAG_LSB + i]
                        && !fault_live[i]) begin
                    s_nxt.fflag[i] = 1'b0;
                end
            end
        end
        if (wr_c2) begin
            s_nxt.con2 = reg_wdata;
            s_nxt.con2[`OCP_C2_UNUSED] = 1'b0;
        end
        if (reg_wr && reg_addr == `OCP_OFS_PRIMARY) begin
            s_nxt.pri = reg_wdata;
        end
        if (reg_wr && reg_addr == `OCP_OFS_SECONDARY) begin
            s_nxt.sec = reg_wdata;
        end

        // Non-PWM modes use written values at once; PWM waits for period end
        if (!pwm || period_start || mode == `OCP_MODE_OFF) begin
            s_nxt.pri_act = s_nxt.pri;
            s_nxt.sec_act = s_nxt.sec;
            s_nxt.dcb_act = s_nxt.con2[`OCP_C2_DCB_LSB +: 2];
        end

        // Trigger status: hardware set wins over the software clear
        if (s_r.autoclr && s_r.tmr == s_r.sec_act) begin
            s_nxt.con2[`OCP_C2_TRIGGER_STATUS] = 1'b0;
        end
        if (trig_mode && sel_evt && !(src == `OCP_SRC_SELF)) begin
            s_nxt.con2[`OCP_C2_TRIGGER_STATUS] = 1'b1;
        end

        // Time base: held clear until triggered, restarted by a sync event
        if (mode == `OCP_MODE_OFF) begin
            s_nxt.tmr = 16'h0000;
        end else if (hold_clear) begin
            s_nxt.tmr = 16'h0000;
        end else if (tick) begin
            if (!trig_mode && sel_evt) begin
                s_nxt.tmr = 16'h0000;
            end else begin
                s_nxt.tmr = tmr_inc;
            end
        end

        // Waveform generation
        case (mode)
            `OCP_MODE_SS_HIGH: begin
                if (pri_hit && s_r.shot == ocp_pkg::SHOT_ARMED) begin
                    s_nxt.core = 1'b1;
                    s_nxt.shot = ocp_pkg::SHOT_DONE;
                end
            end
            `OCP_MODE_SS_LOW: begin
                if (pri_hit && s_r.shot == ocp_pkg::SHOT_ARMED) begin
                    s_nxt.core = 1'b0;
                    s_nxt.shot = ocp_pkg::SHOT_DONE;
                end
            end
            `OCP_MODE_TOGGLE: begin
                if (pri_hit) begin
                    s_nxt.core = !s_r.core;
                end
            end
            `OCP_MODE_DBL_ONE, `OCP_MODE_DBL_CONT: begin
                if (pri_hit && s_r.shot == ocp_pkg::SHOT_ARMED) begin
                    s_nxt.core = 1'b1;
                    s_nxt.shot = ocp_pkg::SHOT_SECOND;
                end else if (sec_hit && s_r.shot == ocp_pkg::SHOT_SECOND) begin
                    s_nxt.core = 1'b0;
                    s_nxt.shot = (mode == `OCP_MODE_DBL_CONT) ? ocp_pkg::SHOT_ARMED
                        : ocp_pkg::SHOT_DONE;
                end
            end
            `OCP_MODE_PWM_EDGE: begin
                // High from period start, low at the primary match
                if (period_start) begin
                    s_nxt.core = (s_nxt.pri_act != 16'h0000);
                end else if (pri_hit) begin
                    s_nxt.core = 1'b0;
                end
            end
            `OCP_MODE_PWM_CENTER: begin
                // Rises at the primary match, falls at the secondary match
                if (sec_hit) begin
                    s_nxt.core = 1'b0;
                end else if (pri_hit) begin
                    s_nxt.core = 1'b1;
                end
            end
            default: begin
                s_nxt.core = 1'b0;
                s_nxt.shot = ocp_pkg::SHOT_ARMED;
            end
        endcase

        // Fault flags: set wins over any clear, center PWM only
        for (int i = 0; i < 3; i++) begin
            if (mode == `OCP_MODE_PWM_CENTER && fault_live[i]) begin
                s_nxt.fflag[i] = 1'b1;
            end else if (!s_r.con2[`OCP_C2_FHOLD] && period_start && !fault_live[i]) begin
                s_nxt.fflag[i] = 1'b0;
            end
        end

        // Falling edge of the core level waits dcb quarters of a cycle;
        // inversion after this stage turns it into the rising edge
        if (s_r.dly != 8'h00) begin
            s_nxt.dly = s_r.dly - 8'h01;
            if (s_r.dly == 8'h01) begin
                s_nxt.lvl = s_nxt.core;
            end
        end else if (s_r.lvl && !s_nxt.core && mode != `OCP_MODE_SS_HIGH
                && s_r.dcb_act != 2'h0) begin
            s_nxt.dly = 8'(QUARTER * int'(s_r.dcb_act));
        end else begin
            s_nxt.lvl = s_nxt.core;
        end
        // A new rise cancels a pending delayed fall
        if (s_nxt.core && !s_r.core) begin
            s_nxt.dly = 8'h00;
            s_nxt.lvl = 1'b1;
        end

        // New mode sets the level last, so the old mode's compare cannot undo it
        if (wr_c1 && reg_wdata[`OCP_C1_MODE_LSB +: 3] != s_r.mode) begin
            s_nxt.shot = ocp_pkg::SHOT_ARMED;
            s_nxt.dly = 8'h00;
            case (reg_wdata[`OCP_C1_MODE_LSB +: 3])
                `OCP_MODE_SS_LOW: s_nxt.core = 1'b1;
                `OCP_MODE_TOGGLE: s_nxt.core = s_r.core;
                default: s_nxt.core = 1'b0;
            endcase
            s_nxt.lvl = s_nxt.core;
        end

        // Read data, one cycle after the strobe
        s_nxt.rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `OCP_OFS_CTRL_ONE: begin
                    s_nxt.rdata[`OCP_C1_MODE_LSB +: 3] = s_r.mode;
                    s_nxt.rdata[`OCP_C1_AUTOCLR] = s_r.autoclr;
                    s_nxt.rdata[`OCP_C1_FLAG_LSB +: 3] = s_r.fflag;
                    s_nxt.rdata[`OCP_C1_FEN_LSB +: 3] = s_r.fen;
                end
                `OCP_OFS_CTRL_TWO: s_nxt.rdata = s_r.con2;
                `OCP_OFS_PRIMARY: s_nxt.rdata = s_r.pri;
                `OCP_OFS_SECONDARY: s_nxt.rdata = s_r.sec;
                `OCP_OFS_TIMER: s_nxt.rdata = s_r.tmr;
                default: s_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // Pin: fault level bypasses inversion so the safe state is absolute
    always_comb begin
        if (fault_active) begin
            compare_output_pin_out = s_r.con2[`OCP_C2_FLEVEL];
        end else begin
            compare_output_pin_out = s_r.con2[`OCP_C2_INVERT] ^ s_r.lvl;
        end
        compare_output_pin_oe = !s_r.con2[`OCP_C2_TRIS];
        if (fault_active && s_r.con2[`OCP_C2_FDIR]) begin
            compare_output_pin_oe = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.con2 <= `OCP_RST_CTRL_TWO;
            s_r.pri <= `OCP_RST_COMPARE;
            s_r.sec <= `OCP_RST_COMPARE;
            s_r.shot <= ocp_pkg::SHOT_ARMED;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

// >>> tb/ocp_channel_checker.sv
// Port checker of the output compare channel, bound to its top module.
// Assumes the register map of ocp_consts.svh; status bits are not shadowed.
`include "ocp_consts.svh"

module ocp_channel_checker #(
    parameter int TCY_CLKS = 4,
    parameter int FAULT_INPUTS = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [`OCP_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Fault pins and output pin
    input wire logic [FAULT_INPUTS-1:0] fault_in,
    input wire logic compare_output_pin_out,
    input wire logic compare_output_pin_oe
);
    logic [15:0] c1_r;
    logic [15:0] c2_r;
    logic [3:0] flt_r;
    logic [1:0] rise_r;
    logic pin_q_r;
    logic [2:0] mode;
    logic [2:0] fen;
    assign mode = c1_r[2:0];
    assign fen = c1_r[9:7];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c1_r <= 16'h0000;
            c2_r <= 16'h000c;
            flt_r <= 4'h0;
            rise_r <= 2'h0;
            pin_q_r <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `OCP_OFS_CTRL_ONE) c1_r <= reg_wdata;
            if (reg_wr && reg_addr == `OCP_OFS_CTRL_TWO) c2_r <= reg_wdata;
            // Only enabled faults count; sync latency is covered by the count
            if ((3'(fault_in) & fen) == 3'h0) flt_r <= 4'h0;
            else if (flt_r != 4'hf) flt_r <= flt_r + 4'h1;
            if (reg_wr) rise_r <= 2'h0;
            else if (compare_output_pin_out && !pin_q_r && rise_r != 2'h3) rise_r <= rise_r + 2'h1;
            pin_q_r <= compare_output_pin_out;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence rd_ctrl_two;
        reg_rd && reg_addr == `OCP_OFS_CTRL_TWO;
    endsequence

    sequence fault_held;
        flt_r >= 4'h8 && mode == `OCP_MODE_PWM_CENTER;
    endsequence

    ctrl_two_read_a: assert property (
        rd_ctrl_two |=> (reg_rdata & 16'hffbf) == ($past(c2_r) & 16'hf7bf))
        else $error("control two read back wrong");
    off_level_a: assert property (
        mode == 3'h0 && $past(mode, 4) == 3'h0 && !c2_r[12] |-> !compare_output_pin_out)
        else $error("disabled channel drives pin high");
    tris_drive_a: assert property (
        !c2_r[5] |-> compare_output_pin_oe)
        else $error("pin not driven with tristate clear");
    tris_float_a: assert property (
        c2_r[5] && !c2_r[13] |-> !compare_output_pin_oe)
        else $error("pin driven with tristate set");
    shot_high_a: assert property (
        mode == 3'h1 && !c2_r[12] && compare_output_pin_out && !reg_wr |=> compare_output_pin_out)
        else $error("single shot high did not stay");
    shot_low_a: assert property (
        mode == 3'h2 && !c2_r[12] && !compare_output_pin_out && !reg_wr |=> !compare_output_pin_out)
        else $error("single shot low did not stay");
    one_pulse_a: assert property (
        (mode == 3'h1 || mode == 3'h4) && !c2_r[12] |-> rise_r <= 2'h1)
        else $error("more than one pulse in single shot");
    fault_level_a: assert property (
        fault_held |-> compare_output_pin_out == c2_r[14])
        else $error("fault level not driven");
    fault_dir_a: assert property (
        fault_held and c2_r[13] |-> compare_output_pin_oe)
        else $error("fault did not force pin output");
endmodule

bind ocp_channel ocp_channel_checker #(
    .TCY_CLKS(TCY_CLKS),
    .FAULT_INPUTS(FAULT_INPUTS)
) u_ocp_channel_checker (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_in(fault_in),
    .compare_output_pin_out(compare_output_pin_out),
    .compare_output_pin_oe(compare_output_pin_oe)
);

// >>> tb/ocp_far_model.sv
// Far side of the channel: source pulses, fault pins and the pin load.
// Assumes bench controls change right after a rising edge.
module ocp_far_model (
    // Bench controls
    input wire logic [4:0] ev_code,
    input wire logic ev_go,
    input wire logic [2:0] flt_lvl,
    // Channel side
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic [31:0] source_events,
    output logic [2:0] fault_in,
    output logic pin_level
);
    // Pull-down on the pin, so a released pin reads low
    assign pin_level = pin_oe ? pin_out : 1'b0;
    assign fault_in = flt_lvl;
    // Own code is never pulsed: a channel may not trigger itself
    assign source_events = (ev_go && ev_code != 5'h1f) ? (32'h1 << ev_code) : 32'h0;
endmodule

// >>> tb/ocp_channel_tb.sv
// Bench of the output compare channel: registers, modes, PWM, faults, trigger.
// Assumes the design, the far model and the bound checker compile first.
`include "ocp_consts.svh"

module ocp_channel_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic rst_n;
    logic [`OCP_ADDR_W-1:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic [31:0] source_events;
    logic [2:0] fault_in;
    logic [2:0] flt_lvl;
    logic [4:0] ev_code;
    logic ev_go;
    logic pin_out;
    logic pin_oe;
    logic pin_level;
    logic carry_in;
    logic match_in;
    logic match_out;
    int errors;
    int check_count;
    int h;
    int e;
    int hm[8];
    int em[8];
    logic [2:0] sm[4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    int si[4] = '{0, 1, 0, 0};
    int sf[4] = '{1, 0, 0, 0};
    int se[4] = '{1, 1, 2, 0};

    ocp_channel #(.TCY_CLKS(4), .FAULT_INPUTS(3)) u_ocp_channel (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .source_events(source_events), .fault_in(fault_in),
        .cascade_carry_in(carry_in), .cascade_match_in(match_in),
        .cascade_carry_out(), .cascade_match_out(match_out),
        .compare_output_pin_out(pin_out), .compare_output_pin_oe(pin_oe));
    ocp_far_model u_ocp_far_model (
        .ev_code(ev_code), .ev_go(ev_go), .flt_lvl(flt_lvl), .pin_out(pin_out),
        .pin_oe(pin_oe), .source_events(source_events), .fault_in(fault_in),
        .pin_level(pin_level));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [`OCP_ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [`OCP_ADDR_W-1:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask

    // Samples at falling edges so pin updates have settled
    task automatic meas(input int len);
        logic prev;
        h = 0;
        e = 0;
        @(negedge clk);
        prev = pin_level;
        repeat (len) begin
            @(negedge clk);
            if (pin_level === 1'b1) h++;
            if (pin_level !== prev) e++;
            prev = pin_level;
        end
    endtask

    task automatic hold(input logic [2:0] f, input int n);
        @(posedge clk);
        flt_lvl <= f;
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // One carry pulse from the lower peer, with its match level
    task automatic carry(input logic m);
        @(posedge clk);
        carry_in <= 1'b1;
        match_in <= m;
        @(posedge clk);
        carry_in <= 1'b0;
    endtask

    task automatic final_report();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        flt_lvl = 3'h0;
        ev_code = 5'h00;
        ev_go = 1'b0;
        carry_in = 1'b0;
        match_in = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(`OCP_OFS_CTRL_TWO, `OCP_RST_CTRL_TWO);
        rd(`OCP_OFS_CTRL_ONE, 16'h0000);
        rd(3'h5, 16'h0000);
        wr(`OCP_OFS_CTRL_TWO, 16'hffbf);
        rd(`OCP_OFS_CTRL_TWO, 16'hf7bf);
        chk(16'(pin_oe), 16'h0000);
        wr(3'h5, 16'hffff);
        rd(3'h5, 16'h0000);
        wr(`OCP_OFS_TIMER, 16'h1234);
        rd(`OCP_OFS_TIMER, 16'h0000);
        wr(`OCP_OFS_CTRL_TWO, 16'h0000);
        wr(`OCP_OFS_PRIMARY, 16'h0006);
        wr(`OCP_OFS_SECONDARY, 16'h0008);
        // Through mode off each time, so the timer restarts from zero
        for (int i = 0; i < 4; i++) begin
            wr(`OCP_OFS_CTRL_ONE, 16'h0000);
            wr(`OCP_OFS_CTRL_ONE, {13'h0000, sm[i]});
            @(negedge clk);
            chk(16'(pin_level), 16'(si[i]));
            meas(60);
            chk(16'(pin_level), 16'(sf[i]));
            chk(16'(e), 16'(se[i]));
        end
        // Self code: the period ends at the secondary match
        wr(`OCP_OFS_CTRL_TWO, 16'h001f);
        for (int m = 3; m < 8; m++) begin
            wr(`OCP_OFS_CTRL_ONE, 16'(m));
            repeat (80) @(posedge clk);
            meas(360);
            hm[m] = h;
            em[m] = e;
        end
        chk(16'(em[3] * 2), 16'(em[5]));
        chk(16'(hm[5]), 16'(em[5] * 4));
        chk(16'(hm[7]), 16'(em[7] * 4));
        chk(16'(em[6]), 16'(em[5]));
        wr(`OCP_OFS_CTRL_ONE, 16'h0006);
        for (int d = 1; d < 8; d++) begin
            int x;
            wr(`OCP_OFS_CTRL_TWO, {3'h0, d[2], 1'b0, d[1:0], 9'h01f});
            repeat (80) @(posedge clk);
            meas(360);
            x = hm[6] + int'(d[1:0]) * em[6] / 2;
            if (d[2]) x = 360 - x;
            chk(16'(h), 16'(x));
        end
        // Cascaded: counts on the peer carry only, matches need the peer
        wr(`OCP_OFS_CTRL_ONE, 16'h0000);
        wr(`OCP_OFS_CTRL_TWO, 16'h0100);
        wr(`OCP_OFS_CTRL_ONE, 16'h0003);
        repeat (20) @(posedge clk);
        rd(`OCP_OFS_TIMER, 16'h0000);
        repeat (6) carry(1'b0);
        rd(`OCP_OFS_TIMER, 16'h0006);
        chk(16'({match_out, pin_level}), 16'h0002);
        carry(1'b0);
        wr(`OCP_OFS_PRIMARY, 16'h0007);
        carry(1'b1);
        @(negedge clk);
        chk(16'({match_out, pin_level}), 16'h0001);
        wr(`OCP_OFS_CTRL_ONE, 16'h0009);
        wr(`OCP_OFS_CTRL_TWO, 16'h0094);
        repeat (20) @(posedge clk);
        rd(`OCP_OFS_TIMER, 16'h0000);
        rd(`OCP_OFS_CTRL_TWO, 16'h0094);
        @(posedge clk);
        ev_code <= 5'h14;
        ev_go <= 1'b1;
        @(posedge clk);
        ev_go <= 1'b0;
        rd(`OCP_OFS_CTRL_TWO, 16'h00d4);
        repeat (40) @(posedge clk);
        rd(`OCP_OFS_CTRL_TWO, 16'h0094);
        wr(`OCP_OFS_CTRL_ONE, 16'h0087);
        wr(`OCP_OFS_CTRL_TWO, 16'h603f);
        hold(3'b010, 20);
        chk(16'({pin_oe, pin_level}), 16'h0000);
        rd(`OCP_OFS_CTRL_ONE, 16'h0087);
        hold(3'b001, 20);
        chk(16'({pin_oe, pin_level}), 16'h0003);
        rd(`OCP_OFS_CTRL_ONE, 16'h0097);
        hold(3'b000, 100);
        chk(16'(pin_oe), 16'h0000);
        wr(`OCP_OFS_CTRL_TWO, 16'he03f);
        hold(3'b001, 20);
        hold(3'b000, 100);
        chk(16'(pin_oe), 16'h0001);
        wr(`OCP_OFS_CTRL_ONE, 16'h0087);
        hold(3'b000, 100);
        chk(16'(pin_oe), 16'h0000);
        final_report();
    end
endmodule
